// ### drive_cfg_defs.svh
// Constants for the drive configuration and brake logic
`ifndef DRIVE_CFG_DEFS_SVH
`define DRIVE_CFG_DEFS_SVH
`define CLK_HZ            50000000
`define BLINK_ON_MS       100
`define BLINK_OFF_MS      300
`define BLINK_ON_CYC      (`CLK_HZ / 1000 * `BLINK_ON_MS)
`define BLINK_OFF_CYC     (`CLK_HZ / 1000 * `BLINK_OFF_MS)
`define STALL_MS          1000
`define STALL_CYC         (`CLK_HZ / 1000 * `STALL_MS)
`define PWM_KHZ_FIXED     8'h04
`define PWM_KHZ_HIGH      8'h10
`define PWM_KHZ_MID       8'h08
`define FAULT_SPEED_MON   8'h08
`define CTRL_BRAKE_BIT    8
`define CTRL_ENABLE_BIT   3
`define ADDR_OFF          8'h00
`define CFG1_OFF          8'h04
`define CFG2_OFF          8'h08
`define STATUS1_OFF       8'h0C
`define CURRENT_OFF       8'h10
`define STATUS2_OFF       8'h14
`define PO_CTRL_OFF       8'h18
`define PO_SPEED_OFF      8'h1C
`define PO_RAMP_OFF       8'h20
`define MODE_OFF          8'h24
`endif

// ### drive_cfg_pkg.sv
// Types for the drive configuration and brake logic
package drive_cfg_pkg;
	typedef enum logic [1:0] {BRK_APPLIED, BRK_DRIVE, BRK_MANUAL} brake_e;
	typedef enum logic [1:0] {PWM_HIGH, PWM_MID, PWM_LOW} pwm_e;
	typedef enum logic [1:0] {BLK_IDLE, BLK_ON, BLK_OFF} blink_e;
endpackage

// ### drive_config_brake_logic.sv
// Switch decoding, brake control and bus process words
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "drive_cfg_defs.svh"
module drive_config_brake_logic
	import drive_cfg_pkg::*;
#(
	parameter int unsigned BLINK_ON_CYC  = `BLINK_ON_CYC,
	parameter int unsigned BLINK_OFF_CYC = `BLINK_OFF_CYC,
	parameter int unsigned STALL_CYC     = `STALL_CYC
)
(
	input  wire logic        CLOCK,
	input  wire logic        RST,
	input  wire logic [7:0]  SWITCH_BANK1,
	input  wire logic [7:0]  SWITCH_BANK2,
	input  wire logic        RUN_RIGHT,
	input  wire logic        RUN_LEFT,
	input  wire logic        SETPOINT_SELECT_INPUT,
	input  wire logic        UNIT_ENABLED,
	input  wire logic        UNIT_FAULT,
	input  wire logic        COMM_TIMEOUT,
	input  wire logic        UNIT_READY,
	input  wire logic        BRAKE_RESISTOR,
	input  wire logic        AT_CURRENT_LIMIT,
	input  wire logic        HEATSINK_WARM,
	input  wire logic        HEATSINK_HOT,
	input  wire logic [15:0] OUTPUT_CURRENT,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	output logic             BRAKE_RELEASE,
	output logic             SETPOINT_SECOND,
	output logic             YELLOW_LED,
	output logic             RED_LED_SLOW,
	output logic      [7:0]  FAULT_CODE,
	output logic      [7:0]  PWM_KHZ,
	output logic             VF_CONTROL,
	output logic             DAMPING_ON,
	output logic             MOTOR_PROTECT_ON,
	output logic             MOTOR_DOWNSIZE,
	output logic             STALL_PROTECT_ON,
	output logic             SPEED_MONITOR_ON,
	output logic      [3:0]  ADDFUNC_CODE,
	output logic      [3:0]  BUS_ADDRESS,
	output logic             TERMINAL_MODE
);
	// Synchronisers for all pin inputs except OUTPUT_CURRENT
	logic [26:0] pin_in;
	logic [26:0] sync1_r;
	logic [26:0] sync2_r;
	assign pin_in = {SWITCH_BANK1, SWITCH_BANK2, RUN_RIGHT, RUN_LEFT, SETPOINT_SELECT_INPUT,
		UNIT_ENABLED, UNIT_FAULT, COMM_TIMEOUT, UNIT_READY, BRAKE_RESISTOR,
		AT_CURRENT_LIMIT, HEATSINK_WARM, HEATSINK_HOT};
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			sync1_r <= 27'h0;
			sync2_r <= 27'h0;
		end
		else
		begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
		end
	end
	logic [7:0] bank1_s;
	logic [7:0] bank2_s;
	logic       run_r_s, run_l_s, sel_s, en_s, flt_s, tmo_s, rdy_s, bres_s, ilim_s, warm_s, hot_s;
	assign bank1_s = sync2_r[26:19];
	assign bank2_s = sync2_r[18:11];
	assign {run_r_s, run_l_s, sel_s, en_s, flt_s, tmo_s, rdy_s, bres_s, ilim_s, warm_s, hot_s}
		= sync2_r[10:0];

	// Switch snapshot taken once after reset release
	logic [7:0] bank1_r, bank1_nxt;
	logic [7:0] bank2_r, bank2_nxt;
	logic [1:0] snap_r, snap_nxt;
	always_comb
	begin
		bank1_nxt = bank1_r;
		bank2_nxt = bank2_r;
		snap_nxt  = snap_r;
		if (snap_r != 2'h3)
			snap_nxt = snap_r + 2'h1;
		if (snap_r == 2'h2)
		begin
			bank1_nxt = bank1_s;
			bank2_nxt = bank2_s;
		end
	end
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			bank1_r <= 8'h00;
			bank2_r <= 8'h00;
			snap_r  <= 2'h0;
		end
		else
		begin
			bank1_r <= bank1_nxt;
			bank2_r <= bank2_nxt;
			snap_r  <= snap_nxt;
		end
	end
	logic cfg_valid;
	assign cfg_valid = (snap_r == 2'h3);

	// Switch decode
	logic [3:0] addr;
	logic       term_mode;
	logic       rel_no_en;
	logic       spd_mon;
	assign addr      = bank1_r[3:0];
	assign term_mode = (addr == 4'h0);
	assign rel_no_en = bank2_r[1] && !bres_s;
	assign spd_mon   = bank2_r[3];

	// Process output words written by the master
	logic [15:0] po_ctrl_r, po_ctrl_nxt;
	logic [15:0] po_speed_r, po_speed_nxt;
	logic [15:0] po_ramp_r, po_ramp_nxt;
	logic        wr_en;
	assign wr_en = PSEL && PENABLE && PWRITE;
	always_comb
	begin
		po_ctrl_nxt  = po_ctrl_r;
		po_speed_nxt = po_speed_r;
		po_ramp_nxt  = po_ramp_r;
		if (wr_en && PADDR == `PO_CTRL_OFF)
			po_ctrl_nxt = PWDATA[15:0];
		else if (wr_en && PADDR == `PO_SPEED_OFF)
			po_speed_nxt = PWDATA[15:0];
		else if (wr_en && PADDR == `PO_RAMP_OFF)
			po_ramp_nxt = PWDATA[15:0];
	end
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			po_ctrl_r  <= 16'h0000;
			po_speed_r <= 16'h0000;
			po_ramp_r  <= 16'h0000;
		end
		else
		begin
			po_ctrl_r  <= po_ctrl_nxt;
			po_speed_r <= po_speed_nxt;
			po_ramp_r  <= po_ramp_nxt;
		end
	end

	// Brake decision
	brake_e brake_sel;
	always_comb
	begin
		brake_sel = BRK_APPLIED;
		if (!rdy_s || !cfg_valid)
			brake_sel = BRK_APPLIED;
		else if (en_s)
			brake_sel = BRK_DRIVE;
		else if (flt_s || (!term_mode && tmo_s))
			brake_sel = BRK_APPLIED;
		else if (!rel_no_en)
			brake_sel = BRK_APPLIED;
		else if (term_mode)
			brake_sel = (!run_r_s && !run_l_s && sel_s) ? BRK_MANUAL : BRK_APPLIED;
		else
			brake_sel = po_ctrl_r[`CTRL_BRAKE_BIT] ? BRK_MANUAL : BRK_APPLIED;
	end

	// Current-limit timer for speed monitoring
	logic [31:0] stall_cnt_r, stall_cnt_nxt;
	logic        trip_r, trip_nxt;
	always_comb
	begin
		stall_cnt_nxt = 32'h0;
		trip_nxt      = trip_r;
		if (spd_mon && ilim_s && cfg_valid)
		begin
			stall_cnt_nxt = stall_cnt_r;
			if (stall_cnt_r < STALL_CYC)
				stall_cnt_nxt = stall_cnt_r + 32'h1;
			else
				trip_nxt = 1'b1;
		end
	end
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			stall_cnt_r <= 32'h0;
			trip_r      <= 1'b0;
		end
		else
		begin
			stall_cnt_r <= stall_cnt_nxt;
			trip_r      <= trip_nxt;
		end
	end

	// Manual-release blink and slow fault blink
	blink_e      blk_r, blk_nxt;
	logic [31:0] blk_cnt_r, blk_cnt_nxt;
	logic [31:0] slow_cnt_r, slow_cnt_nxt;
	logic        slow_r, slow_nxt;
	always_comb
	begin
		blk_nxt     = blk_r;
		blk_cnt_nxt = blk_cnt_r + 32'h1;
		case (blk_r)
			BLK_IDLE:
			begin
				blk_cnt_nxt = 32'h0;
				if (brake_sel == BRK_MANUAL)
					blk_nxt = BLK_ON;
			end
			BLK_ON:
				if (blk_cnt_r == BLINK_ON_CYC - 1)
				begin
					blk_nxt     = BLK_OFF;
					blk_cnt_nxt = 32'h0;
				end
			BLK_OFF:
				if (blk_cnt_r == BLINK_OFF_CYC - 1)
				begin
					blk_nxt     = BLK_ON;
					blk_cnt_nxt = 32'h0;
				end
			default:
				blk_nxt = BLK_IDLE;
		endcase
		if (brake_sel != BRK_MANUAL)
			blk_nxt = BLK_IDLE;
		slow_cnt_nxt = slow_cnt_r + 32'h1;
		slow_nxt     = slow_r;
		if (slow_cnt_r == BLINK_OFF_CYC + BLINK_ON_CYC - 1)
		begin
			slow_cnt_nxt = 32'h0;
			slow_nxt     = !slow_r;
		end
	end
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			blk_r      <= BLK_IDLE;
			blk_cnt_r  <= 32'h0;
			slow_cnt_r <= 32'h0;
			slow_r     <= 1'b0;
		end
		else
		begin
			blk_r      <= blk_nxt;
			blk_cnt_r  <= blk_cnt_nxt;
			slow_cnt_r <= slow_cnt_nxt;
			slow_r     <= slow_nxt;
		end
	end

	// PWM frequency selection
	pwm_e pwm_sel;
	always_comb
	begin
		if (!bank1_r[6])
			pwm_sel = PWM_LOW;
		else if (hot_s)
			pwm_sel = PWM_LOW;
		else if (warm_s)
			pwm_sel = PWM_MID;
		else
			pwm_sel = PWM_HIGH;
	end

	// Registered mode outputs
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			BRAKE_RELEASE    <= 1'b0;
			SETPOINT_SECOND  <= 1'b0;
			YELLOW_LED       <= 1'b0;
			RED_LED_SLOW     <= 1'b0;
			FAULT_CODE       <= 8'h00;
			PWM_KHZ          <= `PWM_KHZ_FIXED;
			VF_CONTROL       <= 1'b0;
			DAMPING_ON       <= 1'b0;
			MOTOR_PROTECT_ON <= 1'b1;
			MOTOR_DOWNSIZE   <= 1'b0;
			STALL_PROTECT_ON <= 1'b1;
			SPEED_MONITOR_ON <= 1'b0;
			ADDFUNC_CODE     <= 4'h0;
			BUS_ADDRESS      <= 4'h0;
			TERMINAL_MODE    <= 1'b1;
		end
		else
		begin
			BRAKE_RELEASE    <= (brake_sel == BRK_MANUAL) || (brake_sel == BRK_DRIVE);
			SETPOINT_SECOND  <= term_mode && en_s && sel_s;
			YELLOW_LED       <= (blk_nxt == BLK_ON);
			RED_LED_SLOW     <= trip_r && slow_r;
			FAULT_CODE       <= trip_r ? `FAULT_SPEED_MON : 8'h00;
			PWM_KHZ          <= (pwm_sel == PWM_HIGH) ? `PWM_KHZ_HIGH :
				(pwm_sel == PWM_MID) ? `PWM_KHZ_MID : `PWM_KHZ_FIXED;
			VF_CONTROL       <= bank2_r[2];
			DAMPING_ON       <= bank1_r[7];
			MOTOR_PROTECT_ON <= !bank1_r[4];
			MOTOR_DOWNSIZE   <= bank1_r[5];
			STALL_PROTECT_ON <= !bank1_r[5];
			SPEED_MONITOR_ON <= spd_mon;
			ADDFUNC_CODE     <= bank2_r[7:4];
			BUS_ADDRESS      <= addr;
			TERMINAL_MODE    <= term_mode;
		end
	end

	// APB read side, zero wait states
	logic [15:0] status1;
	logic [15:0] status2;
	assign status1 = {8'h00, FAULT_CODE[3:0], trip_r, BRAKE_RELEASE, rdy_s, en_s};
	assign status2 = {12'h000, (blk_r != BLK_IDLE), bres_s, tmo_s, flt_s};
	always_comb
	begin
		PRDATA  = 32'h0;
		PSLVERR = 1'b0;
		if (PADDR == `ADDR_OFF)
			PRDATA = {28'h0, addr};
		else if (PADDR == `CFG1_OFF)
			PRDATA = {24'h0, bank1_r};
		else if (PADDR == `CFG2_OFF)
			PRDATA = {24'h0, bank2_r};
		else if (PADDR == `STATUS1_OFF)
			PRDATA = {16'h0, status1};
		else if (PADDR == `CURRENT_OFF)
			PRDATA = {16'h0, OUTPUT_CURRENT};
		else if (PADDR == `STATUS2_OFF)
			PRDATA = {16'h0, status2};
		else if (PADDR == `PO_CTRL_OFF)
			PRDATA = {16'h0, po_ctrl_r};
		else if (PADDR == `PO_SPEED_OFF)
			PRDATA = {16'h0, po_speed_r};
		else if (PADDR == `PO_RAMP_OFF)
			PRDATA = {16'h0, po_ramp_r};
		else if (PADDR == `MODE_OFF)
			PRDATA = {28'h0, pwm_sel == PWM_HIGH, bank2_r[2], bank1_r[7], term_mode};
		else
			PSLVERR = PSEL && PENABLE;
	end
	assign PREADY = 1'b1;

	// Checks
	chk_notready_brake: assert property (@(posedge CLOCK) disable iff (RST)
		!rdy_s |=> !BRAKE_RELEASE)
		else $error("brake released while not ready");
	chk_fault_brake: assert property (@(posedge CLOCK) disable iff (RST)
		(!en_s && flt_s) |=> !BRAKE_RELEASE)
		else $error("brake released with fault");
	chk_bus_release: assert property (@(posedge CLOCK) disable iff (RST)
		(cfg_valid && rdy_s && !en_s && !flt_s && !tmo_s && !term_mode && bank2_r[1]
		&& !bres_s && po_ctrl_r[`CTRL_BRAKE_BIT]) |=> BRAKE_RELEASE)
		else $error("bus bit 8 failed to release brake");
	chk_term_release: assert property (@(posedge CLOCK) disable iff (RST)
		(term_mode && !en_s && (run_r_s || run_l_s || !sel_s)) |=> !BRAKE_RELEASE)
		else $error("terminal release on wrong inputs");
	chk_resistor_inhibit: assert property (@(posedge CLOCK) disable iff (RST)
		(bres_s && !en_s) |=> !BRAKE_RELEASE)
		else $error("release with braking resistor");
	chk_pwm_fixed: assert property (@(posedge CLOCK) disable iff (RST)
		!bank1_r[6] |=> PWM_KHZ == `PWM_KHZ_FIXED)
		else $error("pwm not fixed");
	chk_pwm_high: assert property (@(posedge CLOCK) disable iff (RST)
		(bank1_r[6] && !warm_s && !hot_s) |=> PWM_KHZ == `PWM_KHZ_HIGH)
		else $error("pwm not high");
	chk_stall_follow: assert property (@(posedge CLOCK) disable iff (RST)
		##1 STALL_PROTECT_ON == !$past(bank1_r[5]))
		else $error("stall protection wrong");
	chk_addr_decode: assert property (@(posedge CLOCK) disable iff (RST)
		##1 BUS_ADDRESS == $past(bank1_r[3:0]))
		else $error("address decode wrong");
	chk_addfunc_decode: assert property (@(posedge CLOCK) disable iff (RST)
		##1 ADDFUNC_CODE == $past(bank2_r[7:4]))
		else $error("add function decode wrong");
	chk_snap_hold: assert property (@(posedge CLOCK) disable iff (RST)
		cfg_valid |=> $stable(bank1_r) && $stable(bank2_r))
		else $error("switch snapshot changed");
	chk_trip_code: assert property (@(posedge CLOCK) disable iff (RST)
		trip_r |=> FAULT_CODE == `FAULT_SPEED_MON)
		else $error("fault code not 08");
	chk_blink_on: assert property (@(posedge CLOCK) disable iff (RST)
		(blk_r == BLK_ON) |-> blk_cnt_r < BLINK_ON_CYC)
		else $error("blink on too long");
endmodule

// ### gateway_model.sv
// Bus master model of the fieldbus gateway
`timescale 1ns/1ps
`include "drive_cfg_defs.svh"
module gateway_model
(
	input  wire logic        CLOCK,
	input  wire logic [31:0] PRDATA,
	input  wire logic        PREADY,
	input  wire logic        PSLVERR,
	output logic             PSEL,
	output logic             PENABLE,
	output logic             PWRITE,
	output logic      [7:0]  PADDR,
	output logic      [31:0] PWDATA
);
	logic [31:0] rd;
	logic        err;
	initial
	begin
		PSEL = 1'h0;
		PENABLE = 1'h0;
		PWRITE = 1'h0;
		PADDR = 8'h00;
		PWDATA = 32'h0;
	end
	// One transfer, held until pready is seen high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'h1;
		do
			@(posedge CLOCK);
		while (PREADY !== 1'h1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
		PWDATA <= ~d;
	endtask
	// Process output words: control, speed, ramp
	task automatic send_words(input logic brk);
		xfer(1'h1, `PO_CTRL_OFF, {23'h0, brk, 8'h08});
		xfer(1'h1, `PO_SPEED_OFF, 32'h32);
		xfer(1'h1, `PO_RAMP_OFF, 32'h0A);
	endtask
endmodule

// ### tb_top.sv
// Testbench for the drive configuration and brake logic
`timescale 1ns/1ps
`include "drive_cfg_defs.svh"
module tb_top;
	logic        clock;
	logic        rst;
	logic [7:0]  sw1;
	logic [7:0]  sw2;
	logic        rr;
	logic        rl;
	logic        sel;
	logic        en;
	logic        flt;
	logic        tmo;
	logic        rdy;
	logic        bres;
	logic        lim;
	logic        warm;
	logic        hot;
	logic [15:0] cur;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        brk;
	logic        ssec;
	logic        yel;
	logic        red;
	logic [7:0]  fcode;
	logic [7:0]  pwm;
	logic        vf;
	logic        damp;
	logic        mdown;
	logic        mprot;
	logic        stall;
	logic        spdm;
	logic [3:0]  afc;
	logic [3:0]  badr;
	logic        term;
	int          errors;
	int          n_tests;
	int          cnt;

	drive_config_brake_logic #(.BLINK_ON_CYC(4), .BLINK_OFF_CYC(12), .STALL_CYC(20)) dut_u
	(
		.CLOCK(clock), .RST(rst), .SWITCH_BANK1(sw1), .SWITCH_BANK2(sw2),
		.RUN_RIGHT(rr), .RUN_LEFT(rl), .SETPOINT_SELECT_INPUT(sel), .UNIT_ENABLED(en),
		.UNIT_FAULT(flt), .COMM_TIMEOUT(tmo), .UNIT_READY(rdy), .BRAKE_RESISTOR(bres),
		.AT_CURRENT_LIMIT(lim), .HEATSINK_WARM(warm), .HEATSINK_HOT(hot),
		.OUTPUT_CURRENT(cur), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .BRAKE_RELEASE(brk), .SETPOINT_SECOND(ssec),
		.YELLOW_LED(yel), .RED_LED_SLOW(red), .FAULT_CODE(fcode), .PWM_KHZ(pwm),
		.VF_CONTROL(vf), .DAMPING_ON(damp), .MOTOR_PROTECT_ON(mprot), .MOTOR_DOWNSIZE(mdown),
		.STALL_PROTECT_ON(stall), .SPEED_MONITOR_ON(spdm), .ADDFUNC_CODE(afc),
		.BUS_ADDRESS(badr), .TERMINAL_MODE(term)
	);

	gateway_model gw_u
	(
		.CLOCK(clock), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata)
	);

	initial
	begin
		clock = 1'h0;
		forever
			#10 clock = ~clock;
	end

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask

	task automatic w(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic boot(input logic [7:0] a, input logic [7:0] b);
		@(posedge clock);
		sw1 <= a;
		sw2 <= b;
		rst <= 1'h1;
		w(8);
		rst <= 1'h0;
		w(6);
	endtask

	task automatic rd(input logic [7:0] a);
		gw_u.xfer(1'h0, a, 32'h0);
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		repeat (5000) @(posedge clock);
		errors++;
		end_sim;
	end

	initial
	begin
		{rst, rdy} = 2'h3;
		{sw1, sw2, cur} = 32'h0;
		{rr, rl, sel, en, flt, tmo, bres, lim, warm, hot} = 10'h0;
		boot(8'hA5, 8'hB6);
		chk("addr", 32'h5, badr);
		chk("term", 32'h0, term);
		chk("mdown", 32'h1, mdown);
		chk("stall", 32'h0, stall);
		chk("pwm", 32'h4, pwm);
		chk("damp", 32'h1, damp);
		chk("vf", 32'h1, vf);
		chk("spdm", 32'h0, spdm);
		chk("mprot", 32'h1, mprot);
		chk("afc", 32'hB, afc);
		sw1 <= 8'h00;
		w(6);
		chk("held addr", 32'h5, badr);
		gw_u.xfer(1'h1, `ADDR_OFF, 32'hF);
		rd(`ADDR_OFF);
		chk("rd addr", 32'h5, gw_u.rd);
		rd(`CFG1_OFF);
		chk("snapshot one", 32'hA5, gw_u.rd);
		rd(`MODE_OFF);
		chk("mode bus", 32'h6, gw_u.rd);
		rd(8'h40);
		chk("unmapped err", 32'h1, gw_u.err);
		chk("unmapped rd", 32'h0, gw_u.rd);
		$display("test decode done");
		gw_u.send_words(1'h1);
		w(2);
		chk("bus release", 32'h1, brk);
		cnt = 0;
		repeat (32)
		begin
			@(posedge clock);
			cnt += (yel === 1'h1);
		end
		chk("blink on cycles", 32'h8, cnt);
		cur <= 16'h1234;
		rd(`STATUS1_OFF);
		chk("status one brake", 32'h1, gw_u.rd[2]);
		rd(`CURRENT_OFF);
		chk("current", 32'h1234, gw_u.rd);
		rd(`STATUS2_OFF);
		chk("status two blink", 32'h1, gw_u.rd[3]);
		bres <= 1'h1;
		w(4);
		chk("resistor", 32'h0, brk);
		bres <= 1'h0;
		tmo <= 1'h1;
		w(4);
		chk("timeout", 32'h0, brk);
		tmo <= 1'h0;
		rdy <= 1'h0;
		w(4);
		chk("not ready", 32'h0, brk);
		rdy <= 1'h1;
		w(4);
		chk("ready again", 32'h1, brk);
		gw_u.send_words(1'h0);
		w(2);
		chk("bus apply", 32'h0, brk);
		rd(`PO_CTRL_OFF);
		chk("control rw", 32'h8, gw_u.rd);
		rd(`PO_SPEED_OFF);
		chk("speed rw", 32'h32, gw_u.rd);
		rd(`PO_RAMP_OFF);
		chk("ramp rw", 32'hA, gw_u.rd);
		$display("test bus brake done");
		boot(8'h50, 8'h0A);
		chk("term", 32'h1, term);
		chk("pwm16", 32'h10, pwm);
		chk("addr zero", 32'h0, badr);
		chk("vf off", 32'h0, vf);
		chk("damp off", 32'h0, damp);
		chk("mdown off", 32'h0, mdown);
		chk("stall on", 32'h1, stall);
		chk("spdm on", 32'h1, spdm);
		chk("afc zero", 32'h0, afc);
		chk("mprot off", 32'h0, mprot);
		rd(`MODE_OFF);
		chk("mode terminal", 32'h9, gw_u.rd);
		rd(`CFG2_OFF);
		chk("snapshot two", 32'hA, gw_u.rd);
		warm <= 1'h1;
		w(4);
		chk("pwm8", 32'h8, pwm);
		hot <= 1'h1;
		w(4);
		chk("pwm4", 32'h4, pwm);
		for (int i = 0; i < 8; i++)
		begin
			{rr, rl, sel} <= i[2:0];
			w(4);
			chk("terminal idle", {31'h0, i == 1}, brk);
		end
		{rr, rl, sel} <= 3'h1;
		flt <= 1'h1;
		w(4);
		chk("terminal fault", 32'h0, brk);
		{flt, en, rr} <= 3'h3;
		w(4);
		chk("second setpoint", 32'h1, ssec);
		sel <= 1'h0;
		w(4);
		chk("first setpoint", 32'h0, ssec);
		en <= 1'h0;
		lim <= 1'h1;
		w(10);
		lim <= 1'h0;
		w(40);
		chk("short limit", 32'h0, fcode);
		lim <= 1'h1;
		w(40);
		chk("trip code", 32'h8, fcode);
		cnt = 0;
		repeat (32)
		begin
			@(posedge clock);
			cnt += (red === 1'h1);
		end
		chk("red slow blink", 32'h10, cnt);
		$display("test terminal done");
		end_sim;
	end
endmodule
